// ### dtoda_map.svh
`ifndef DTODA_MAP_SVH
`define DTODA_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define DTODA_ADDR_SEC 8'h00
`define DTODA_ADDR_MIN 8'h01
`define DTODA_ADDR_HOUR 8'h02
`define DTODA_ADDR_WDAY 8'h03
`define DTODA_ADDR_MDAY 8'h04
`define DTODA_ADDR_TIME_LAST 8'h06
`define DTODA_ADDR_A1_SEC 8'h07
`define DTODA_ADDR_A1_MIN 8'h08
`define DTODA_ADDR_A1_HOUR 8'h09
`define DTODA_ADDR_A1_DD 8'h0a
`define DTODA_ADDR_A2_MIN 8'h0b
`define DTODA_ADDR_A2_HOUR 8'h0c
`define DTODA_ADDR_A2_DD 8'h0d
`define DTODA_ADDR_CTRL 8'h0e
`define DTODA_ADDR_STAT 8'h0f

// ------------------------------------------------------------
// alarm memory slots, counted from the first alarm register
// ------------------------------------------------------------
`define DTODA_ALARM_SLOTS 7
`define DTODA_SLOT_A1_SEC 3'h0
`define DTODA_SLOT_A1_MIN 3'h1
`define DTODA_SLOT_A1_HOUR 3'h2
`define DTODA_SLOT_A1_DD 3'h3
`define DTODA_SLOT_A2_MIN 3'h4
`define DTODA_SLOT_A2_HOUR 3'h5
`define DTODA_SLOT_A2_DD 3'h6

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DTODA_MASK_BIT 7
`define DTODA_DAYSEL_BIT 6
`define DTODA_CTRL_OSC_RUN_CONTROL_N 7
`define DTODA_CTRL_RS2 4
`define DTODA_CTRL_RS1 3
`define DTODA_CTRL_INTERRUPT_ROUTING_SELECT 2
`define DTODA_CTRL_SECOND_ALARM_IRQ_ENABLE 1
`define DTODA_CTRL_FIRST_ALARM_IRQ_ENABLE 0
`define DTODA_STAT_OSF 7
`define DTODA_STAT_A2F 1
`define DTODA_STAT_A1F 0

// ------------------------------------------------------------
// reset values, write masks, constants
// ------------------------------------------------------------
`define DTODA_CTRL_RESET 8'h1c
`define DTODA_CTRL_WMASK 8'h9f
`define DTODA_ALARM_RESET 8'h00
`define DTODA_OSF_RESET 1'h1
`define DTODA_ZERO_SEC 7'h00
`define DTODA_A1_ALL 4'hf
`define DTODA_A1_SEC_ONLY 4'he
`define DTODA_A1_MIN_SEC 4'hc
`define DTODA_A1_HMS 4'h8
`define DTODA_A1_NONE 4'h0
`define DTODA_A2_ALL 3'h7
`define DTODA_A2_MIN_ONLY 3'h6
`define DTODA_A2_HM 3'h4
`define DTODA_A2_NONE 3'h0
`define DTODA_SLAVE_ADDR 7'h68
`define DTODA_BITS_PER_BYTE 4'h8

`endif

// ### dtoda_pkg.sv
package dtoda_pkg;
   // current time as presented by the counter chain
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] wday;
      logic [7:0] mday;
   } dtoda_time_t;

   // one register write, from the serial slave or toward the counters
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } dtoda_wr_t;

   // serial slave states
   typedef enum logic [2:0] {
      SL_IDLE,
      SL_DEV,
      SL_ACK,
      SL_WR,
      SL_RD,
      SL_RACK
   } dtoda_sl_state_t;
endpackage

// ### dtoda_i2c_slave.sv
`include "dtoda_map.svh"

module dtoda_i2c_slave #(
   parameter logic [6:0] SLAVE_ADDR = `DTODA_SLAVE_ADDR
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOe,
   output dtoda_pkg::dtoda_wr_t regWr,
   output logic [7:0] rdAddr,
   input wire logic [7:0] rdData
);
   import dtoda_pkg::*;

   // the general call address would make the device answer everybody
   if (SLAVE_ADDR == 7'h00) begin : g_chk
      $error("slave address must not be the general call address");
   end

   logic sclS1, sclS2, sclP, sdaS1, sdaS2, sdaP;
   logic start, stop, sclRise, sclFall;
   dtoda_sl_state_t state;
   logic [3:0] bitCnt;
   logic [7:0] shReg, txSh, ptr, ptrInc;
   logic rw, firstByte, nack;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // the third flop only serves the edge detect, never the first one
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         {sclS1, sclS2, sclP} <= 3'h7;
         {sdaS1, sdaS2, sdaP} <= 3'h7;
      end else begin
         {sclS1, sclS2, sclP} <= {sclIn, sclS1, sclS2};
         {sdaS1, sdaS2, sdaP} <= {sdaIn, sdaS1, sdaS2};
      end
   end

   assign start = sclS2 && sdaP && !sdaS2;
   assign stop = sclS2 && !sdaP && sdaS2;
   assign sclRise = sclS2 && !sclP;
   assign sclFall = !sclS2 && sclP;
   // pointer wraps from status back to seconds
   assign ptrInc = (ptr == `DTODA_ADDR_STAT) ? `DTODA_ADDR_SEC : ptr + 8'h01;
   assign rdAddr = ptr;

   // ------------------------------------------------------------
   // byte engine
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= SL_IDLE;
         bitCnt <= 4'h0;
         shReg <= 8'h00;
         txSh <= 8'h00;
         ptr <= 8'h00;
         rw <= 1'b0;
         firstByte <= 1'b1;
         nack <= 1'b0;
         sdaOe <= 1'b0;
         regWr <= '0;
      end else begin
         regWr.valid <= 1'b0;
         if (start) begin
            state <= SL_DEV;
            bitCnt <= 4'h0;
            firstByte <= 1'b1;
            sdaOe <= 1'b0;
         end else if (stop) begin
            state <= SL_IDLE;
            sdaOe <= 1'b0;
         end else if (sclRise) begin
            if (state == SL_DEV || state == SL_WR) begin
               shReg <= {shReg[6:0], sdaS2};
               bitCnt <= bitCnt + 4'h1;
            end else if (state == SL_RD) begin
               bitCnt <= bitCnt + 4'h1;
            end else if (state == SL_RACK) begin
               nack <= sdaS2;
            end
         end else if (sclFall) begin
            case (state)
               SL_DEV: begin
                  if (bitCnt == `DTODA_BITS_PER_BYTE) begin
                     if (shReg[7:1] == SLAVE_ADDR) begin
                        rw <= shReg[0];
                        sdaOe <= 1'b1;
                        state <= SL_ACK;
                     end else begin
                        state <= SL_IDLE;
                     end
                  end
               end
               SL_WR: begin
                  if (bitCnt == `DTODA_BITS_PER_BYTE) begin
                     sdaOe <= 1'b1;
                     state <= SL_ACK;
                     firstByte <= 1'b0;
                     if (firstByte) begin
                        ptr <= shReg;
                     end else begin
                        regWr <= '{valid: 1'b1, addr: ptr, data: shReg};
                        ptr <= ptrInc;
                     end
                  end
               end
               SL_ACK, SL_RACK: begin
                  bitCnt <= 4'h0;
                  if (state == SL_RACK && nack) begin
                     sdaOe <= 1'b0;
                     state <= SL_IDLE;
                  end else if (rw) begin
                     // fetch at the ack fall so the first bit meets setup
                     txSh <= rdData;
                     sdaOe <= !rdData[7];
                     ptr <= ptrInc;
                     state <= SL_RD;
                  end else begin
                     sdaOe <= 1'b0;
                     state <= SL_WR;
                  end
               end
               SL_RD: begin
                  if (bitCnt == `DTODA_BITS_PER_BYTE) begin
                     sdaOe <= 1'b0;
                     state <= SL_RACK;
                  end else begin
                     txSh <= {txSh[6:0], 1'b0};
                     sdaOe <= !txSh[6];
                  end
               end
               default: begin
                  sdaOe <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ### dtoda_alarm_top.sv
// Summary of operation
// - bit 7 of each alarm register masks that field out of the compare.
// - with no masks set, alarm 1 needs time registers 00h to 02h plus 03h or 04h per the day/date bit to match.
// - day/date bit 6 picks date of month at 0, weekday at 1.
// - a match sets that alarm's flag bit in the status register.
// - a set flag with its enable drives the assigned interrupt pin.
// - matches are checked only on the once-per-second update.
// - routing bit chooses separate interrupt pins or one shared pin.
// - alarm 1 with all masks set fires every second.
// - alarm 1 with only seconds unmasked fires when seconds match.
// - alarm 1 with seconds and minutes unmasked needs both to match.
// - alarm 1 with only day/date masked needs hours, minutes, seconds.
// - alarm 1 unmasked needs time plus date or weekday per selector.
// - alarm 2 fully masked fires once a minute at zero seconds.
// - alarm 2 with only minutes unmasked fires when minutes match.
// - alarm 2 with day/date masked needs hours and minutes to match.
// - alarm 2 unmasked needs hours, minutes and date or weekday.
// - hour format bit: 0 is 24-hour, 1 is 12-hour with am/pm.
`include "dtoda_map.svh"

module dtoda_alarm_top #(
   parameter logic [6:0] SLAVE_ADDR = `DTODA_SLAVE_ADDR
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire dtoda_pkg::dtoda_time_t curTime,
   input wire logic secondTick,
   input wire logic squareWave,
   input wire logic oscHaltedIn,
   output dtoda_pkg::dtoda_wr_t timeWrite,
   output logic oscRunControlN,
   output logic waveRateSelHi,
   output logic waveRateSelLo,
   output logic primaryIrqOutN,
   output logic waveOrSecondaryIrqOutN
);
   import dtoda_pkg::*;

   logic [7:0] alarmMem [0:`DTODA_ALARM_SLOTS-1];
   logic [7:0] ctrl_reg;
   logic firstAlarmFlag_reg, secondAlarmFlag_reg, oscHaltedFlag_reg;
   logic oscS1, oscS2;
   logic sdaOeSlave;
   dtoda_wr_t regWr;
   logic [7:0] rdAddr, rdData;
   logic [2:0] wrSlot, rdSlot;
   logic statWrite;

   // ------------------------------------------------------------
   // serial register access
   // ------------------------------------------------------------
   dtoda_i2c_slave #(
      .SLAVE_ADDR(SLAVE_ADDR)
   ) u_slave (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .sclIn(sclIn),
      .sdaIn(sdaIn),
      .sdaOe(sdaOeSlave),
      .regWr(regWr),
      .rdAddr(rdAddr),
      .rdData(rdData)
   );

   // open drain: the pin only ever pulls low
   assign sdaOut = 1'b0;
   assign sdaOe = sdaOeSlave; // straight from the slave's flop

   assign wrSlot = 3'(regWr.addr - `DTODA_ADDR_A1_SEC);
   assign rdSlot = 3'(rdAddr - `DTODA_ADDR_A1_SEC);
   assign statWrite = regWr.valid && (regWr.addr == `DTODA_ADDR_STAT);

   // ------------------------------------------------------------
   // alarm register storage
   // ------------------------------------------------------------
   // reset to zero so a fresh part never fires on garbage settings
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < `DTODA_ALARM_SLOTS; i++) begin
            alarmMem[i] <= `DTODA_ALARM_RESET;
         end
      end else if (regWr.valid && regWr.addr >= `DTODA_ADDR_A1_SEC &&
                   regWr.addr <= `DTODA_ADDR_A2_DD) begin
         alarmMem[wrSlot] <= regWr.data;
      end
   end

   // control register; unused bits are held at zero
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_reg <= `DTODA_CTRL_RESET;
      end else if (regWr.valid && regWr.addr == `DTODA_ADDR_CTRL) begin
         ctrl_reg <= regWr.data & `DTODA_CTRL_WMASK;
      end
   end

   // time writes are handed to the counter chain, which owns those registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         timeWrite <= '0;
      end else begin
         timeWrite.valid <= regWr.valid && (regWr.addr <= `DTODA_ADDR_TIME_LAST);
         timeWrite.addr <= regWr.addr;
         timeWrite.data <= regWr.data;
      end
   end

   // ------------------------------------------------------------
   // read multiplexer
   // ------------------------------------------------------------
   // month and year live outside this block and read as zero here
   always_comb begin
      rdData = 8'h00;
      case (rdAddr)
         `DTODA_ADDR_SEC: rdData = curTime.sec;
         `DTODA_ADDR_MIN: rdData = curTime.min;
         `DTODA_ADDR_HOUR: rdData = curTime.hour;
         `DTODA_ADDR_WDAY: rdData = curTime.wday;
         `DTODA_ADDR_MDAY: rdData = curTime.mday;
         `DTODA_ADDR_CTRL: rdData = ctrl_reg;
         `DTODA_ADDR_STAT: begin
            rdData[`DTODA_STAT_OSF] = oscHaltedFlag_reg;
            rdData[`DTODA_STAT_A2F] = secondAlarmFlag_reg;
            rdData[`DTODA_STAT_A1F] = firstAlarmFlag_reg;
         end
         default: begin
            if (rdAddr >= `DTODA_ADDR_A1_SEC && rdAddr <= `DTODA_ADDR_A2_DD) begin
               rdData = alarmMem[rdSlot];
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // alarm comparison
   // ------------------------------------------------------------
   logic [7:0] a1Sec, a1Min, a1Hour, a1Dd, a2Min, a2Hour, a2Dd;
   logic [3:0] firstMasks;
   logic [2:0] secondMasks;
   logic a1SecEq, a1MinEq, a1HourEq, a1DdEq, a2MinEq, a2HourEq, a2DdEq;
   logic a1PatOk, a2PatOk, a1Hit, a2Hit, secZero;

   // day/date field: selector picks weekday or date of month
   function automatic logic ddMatch(input logic [7:0] alarm, input dtoda_time_t t);
      ddMatch = alarm[`DTODA_DAYSEL_BIT] ? (alarm[5:0] == t.wday[5:0]) :
                                           (alarm[5:0] == t.mday[5:0]);
   endfunction

   assign a1Sec = alarmMem[`DTODA_SLOT_A1_SEC];
   assign a1Min = alarmMem[`DTODA_SLOT_A1_MIN];
   assign a1Hour = alarmMem[`DTODA_SLOT_A1_HOUR];
   assign a1Dd = alarmMem[`DTODA_SLOT_A1_DD];
   assign a2Min = alarmMem[`DTODA_SLOT_A2_MIN];
   assign a2Hour = alarmMem[`DTODA_SLOT_A2_HOUR];
   assign a2Dd = alarmMem[`DTODA_SLOT_A2_DD];

   // mask bits pulled from the top bit of each alarm field
   assign firstMasks = {a1Dd[`DTODA_MASK_BIT], a1Hour[`DTODA_MASK_BIT],
                        a1Min[`DTODA_MASK_BIT], a1Sec[`DTODA_MASK_BIT]};
   assign secondMasks = {a2Dd[`DTODA_MASK_BIT], a2Hour[`DTODA_MASK_BIT],
                         a2Min[`DTODA_MASK_BIT]};

   // field compares; the hour compare includes the 12/24 bit and am/pm,
   // so a mismatched hour system simply never matches
   assign a1SecEq = a1Sec[6:0] == curTime.sec[6:0];
   assign a1MinEq = a1Min[6:0] == curTime.min[6:0];
   assign a1HourEq = a1Hour[6:0] == curTime.hour[6:0];
   assign a1DdEq = ddMatch(a1Dd, curTime);
   assign a2MinEq = a2Min[6:0] == curTime.min[6:0];
   assign a2HourEq = a2Hour[6:0] == curTime.hour[6:0];
   assign a2DdEq = ddMatch(a2Dd, curTime);
   assign secZero = curTime.sec[6:0] == `DTODA_ZERO_SEC;

   // only the listed mask patterns raise an alarm; the rest are ignored
   always_comb begin
      case (firstMasks)
         `DTODA_A1_ALL: a1PatOk = 1'b1;
         `DTODA_A1_SEC_ONLY: a1PatOk = 1'b1;
         `DTODA_A1_MIN_SEC: a1PatOk = 1'b1;
         `DTODA_A1_HMS: a1PatOk = 1'b1;
         `DTODA_A1_NONE: a1PatOk = 1'b1;
         default: a1PatOk = 1'b0;
      endcase
   end

   always_comb begin
      case (secondMasks)
         `DTODA_A2_ALL: a2PatOk = 1'b1;
         `DTODA_A2_MIN_ONLY: a2PatOk = 1'b1;
         `DTODA_A2_HM: a2PatOk = 1'b1;
         `DTODA_A2_NONE: a2PatOk = 1'b1;
         default: a2PatOk = 1'b0;
      endcase
   end

   // a set mask bit forces its field to count as matched
   assign a1Hit = a1PatOk && (firstMasks[0] || a1SecEq) && (firstMasks[1] || a1MinEq) &&
                  (firstMasks[2] || a1HourEq) && (firstMasks[3] || a1DdEq);
   // alarm 2 has no seconds field, so it always waits for second zero
   assign a2Hit = a2PatOk && secZero && (secondMasks[0] || a2MinEq) &&
                  (secondMasks[1] || a2HourEq) && (secondMasks[2] || a2DdEq);

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   // compare only on the update strobe; a continuous compare would
   // refire on every clock while the seconds value stands
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         firstAlarmFlag_reg <= 1'b0;
      end else if (secondTick && a1Hit) begin
         firstAlarmFlag_reg <= 1'b1;
      end else if (statWrite && !regWr.data[`DTODA_STAT_A1F]) begin
         firstAlarmFlag_reg <= 1'b0;
      end
   end

   // writing one leaves the flag as it is; set beats a same-cycle clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         secondAlarmFlag_reg <= 1'b0;
      end else if (secondTick && a2Hit) begin
         secondAlarmFlag_reg <= 1'b1;
      end else if (statWrite && !regWr.data[`DTODA_STAT_A2F]) begin
         secondAlarmFlag_reg <= 1'b0;
      end
   end

   // oscillator stop indication comes from the analogue side: synchronise it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         oscS1 <= 1'b0;
         oscS2 <= 1'b0;
      end else begin
         oscS1 <= oscHaltedIn;
         oscS2 <= oscS1;
      end
   end

   // flagged at reset since time cannot be trusted until software checks it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         oscHaltedFlag_reg <= `DTODA_OSF_RESET;
      end else if (oscS2) begin
         oscHaltedFlag_reg <= 1'b1;
      end else if (statWrite && !regWr.data[`DTODA_STAT_OSF]) begin
         oscHaltedFlag_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // interrupt and control outputs
   // ------------------------------------------------------------
   logic firstIrq, secondIrq, interrupt_routing_select;
   assign firstIrq = firstAlarmFlag_reg && ctrl_reg[`DTODA_CTRL_FIRST_ALARM_IRQ_ENABLE];
   assign secondIrq = secondAlarmFlag_reg && ctrl_reg[`DTODA_CTRL_SECOND_ALARM_IRQ_ENABLE];
   assign interrupt_routing_select = ctrl_reg[`DTODA_CTRL_INTERRUPT_ROUTING_SELECT];

   // routing 1: each alarm on its own pin; routing 0: both share the
   // primary pin and the secondary pin carries the square wave
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         primaryIrqOutN <= 1'b1;
         waveOrSecondaryIrqOutN <= 1'b1;
      end else begin
         primaryIrqOutN <= !(firstIrq || (!interrupt_routing_select && secondIrq));
         waveOrSecondaryIrqOutN <= interrupt_routing_select ? !secondIrq : squareWave;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         oscRunControlN <= 1'b0;
         waveRateSelHi <= 1'b0;
         waveRateSelLo <= 1'b0;
      end else begin
         oscRunControlN <= ctrl_reg[`DTODA_CTRL_OSC_RUN_CONTROL_N];
         waveRateSelHi <= ctrl_reg[`DTODA_CTRL_RS2];
         waveRateSelLo <= ctrl_reg[`DTODA_CTRL_RS1];
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_FLAG1_ON_MATCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
      secondTick && a1Hit |=> firstAlarmFlag_reg)
      else $error("alarm 1 match did not set its flag");

   AST_FLAG_ONLY_ON_TICK: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(firstAlarmFlag_reg) || $rose(secondAlarmFlag_reg) |-> $past(secondTick))
      else $error("alarm flag rose without a second update");

   AST_PRIMARY_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
      firstAlarmFlag_reg && ctrl_reg[`DTODA_CTRL_FIRST_ALARM_IRQ_ENABLE] |=> !primaryIrqOutN)
      else $error("primary interrupt not asserted for alarm 1");

   AST_SEPARATE_ROUTE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      interrupt_routing_select && secondIrq && !firstIrq |=> !waveOrSecondaryIrqOutN && primaryIrqOutN)
      else $error("alarm 2 not routed to its own pin");

   AST_COMMON_ROUTE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !interrupt_routing_select && secondIrq |=> !primaryIrqOutN ##0 waveOrSecondaryIrqOutN == $past(squareWave))
      else $error("shared routing wrong");

   AST_EVERY_SECOND: assert property (@(posedge sys_clk) disable iff (!rst_n)
      secondTick && firstMasks == `DTODA_A1_ALL |=> firstAlarmFlag_reg)
      else $error("fully masked alarm 1 did not fire");

   AST_SECONDS_MATCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
      secondTick && firstMasks == `DTODA_A1_SEC_ONLY && a1SecEq |=> firstAlarmFlag_reg)
      else $error("alarm 1 seconds match missed");

   AST_A2_ZERO_SECONDS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(secondAlarmFlag_reg) |-> $past(curTime.sec[6:0]) == `DTODA_ZERO_SEC)
      else $error("alarm 2 fired away from zero seconds");

   AST_FLAG_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      firstAlarmFlag_reg && !(statWrite && !regWr.data[`DTODA_STAT_A1F])
      |=> firstAlarmFlag_reg)
      else $error("alarm 1 flag dropped without a clearing write");

   AST_UNMASKED_DATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      secondTick && firstMasks == `DTODA_A1_NONE && !a1DdEq && !firstAlarmFlag_reg
      |=> !firstAlarmFlag_reg)
      else $error("alarm 1 fired without day or date match");
endmodule

// ### dtoda_i2c_host.sv
module dtoda_i2c_host (
   input wire logic sys_clk,
   input wire logic sdaBus,
   output logic scl,
   output logic sdaLow
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus: both lines left to the pull-ups
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   // one clock phase; six cycles clears the three the slave needs
   task automatic ph();
      repeat (6) @(negedge sys_clk);
   endtask
   // start, or a repeated start when scl is low
   task automatic start();
      sdaLow = 1'b0;
      ph();
      scl = 1'b1;
      ph();
      sdaLow = 1'b1;
      ph();
      scl = 1'b0;
   endtask
   task automatic stop();
      sdaLow = 1'b1;
      ph();
      scl = 1'b1;
      ph();
      sdaLow = 1'b0;
      ph();
   endtask
   // eight bits msb first plus the acknowledge slot; data moves only while scl is low
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         ph();
         sdaLow = !d[i];
         ph();
         scl = 1'b1;
         ph();
         q[i] = sdaBus;
         scl = 1'b0;
      end
   endtask
endmodule

// ### dtoda_alarm_top_bench.sv
module dtoda_alarm_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import dtoda_pkg::*;
   logic sys_clk = 0, rst_n = 0, secondTick = 0, squareWave = 0, sclIn, sdaLow, sdaOe, sdaOut;
   logic oscRunControlN, waveRateSelHi, waveRateSelLo, pIrqN, sIrqN;
   logic [8:0] q;
   logic [1:0] pn;
   dtoda_time_t curTime = '0;
   dtoda_wr_t timeWrite;
   wire logic sdaBus = !(sdaLow | sdaOe);
   int failures = 0, compares = 0, cycles = 0;
   logic [55:0] al[11] = '{56'h80808080808080, 56'h80808080808080, 56'h00808080458080,
      56'h01808080468080, 56'h00458080451280, 56'h00448080451180, 56'h00455280455217,
      56'h00451217451243, 56'h00451257451203, 56'h80458080801280, 56'h01808080458080};
   logic [39:0] tm[11] = '{40'h3045120317, 40'h0045120317, 40'h0045120317, 40'h0045120317,
      40'h0045120317, 40'h0045120317, 40'h0045520317, 40'h0045120317, 40'h0045120317,
      40'h0045120317, 40'h0045120317};
   logic [1:0] ex[11] = '{2'h1, 2'h3, 2'h3, 2'h0, 2'h3, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 2'h2};
   dtoda_alarm_top uut (.sys_clk, .rst_n, .sclIn, .sdaIn(sdaBus), .sdaOut, .sdaOe, .curTime,
      .secondTick, .squareWave, .oscHaltedIn(1'b0), .timeWrite, .oscRunControlN,
      .waveRateSelHi, .waveRateSelLo, .primaryIrqOutN(pIrqN), .waveOrSecondaryIrqOutN(sIrqN));
   dtoda_i2c_host host (.sys_clk, .sdaBus, .scl(sclIn), .sdaLow);
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // a hung handshake would stall forever, so cap the run well above its length
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 50000) begin
         failures++;
         results();
      end
   end
   // the time-write pulse lasts one cycle, so latch it where it is settled
   logic [15:0] twSeen = '0;
   always @(negedge sys_clk) begin
      if (timeWrite.valid) twSeen <= {timeWrite.addr, timeWrite.data};
   end
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic wb(input logic [7:0] b);
      host.xfer({b, 1'b1}, q);
      chk(8'h00, 8'(q[0]));
   endtask
   // pointer then n data bytes, highest byte first
   task automatic wr(input logic [7:0] a, input logic [63:0] d, input int n);
      host.start();
      wb(8'hd0);
      wb(a);
      for (int i = 0; i < n; i++) wb(d[8*(n-1-i) +: 8]);
      host.stop();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      wr(a, 64'h0, 0);
      host.start();
      wb(8'hd1);
      host.xfer(9'h1ff, q);
      host.stop();
      chk(e, q[8:1]);
   endtask
   // a matching time without the update pulse must leave the pins alone
   task automatic tick(input logic [39:0] t, input logic [7:0] s, input logic [1:0] p);
      curTime = t;
      repeat (4) @(negedge sys_clk);
      chk(8'h03, {6'h0, pIrqN, sIrqN});
      secondTick = 1'b1;
      @(negedge sys_clk);
      secondTick = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk({6'h0, p}, {6'h0, pIrqN, sIrqN});
      rd(8'h0f, s);
   endtask
   task automatic results();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk(8'h03, {5'h0, oscRunControlN, waveRateSelHi, waveRateSelLo});
      chk(8'h00, {7'h0, sdaOut});
      rd(8'h0e, 8'h1c);
      rd(8'h0f, 8'h80);
      wr(8'h05, 8'h5a, 1);
      chk(8'h05, twSeen[15:8]);
      chk(8'h5a, twSeen[7:0]);
      rd(8'h05, 8'h00);
      wr(8'h0e, 8'h07, 1);
      // mask patterns, day/date selector and 12-hour compare, one case per row
      for (int i = 0; i < 11; i++) begin
         wr(8'h07, {8'h0, al[i]}, 7);
         wr(8'h0f, 64'h0, 1);
         // pins are {primary, secondary}, active low: alarm 1 first, alarm 2 second
         pn = ~{ex[i][0], ex[i][1]};
         tick(tm[i], 8'(ex[i]), pn);
      end
      // shared routing: second alarm lands on the primary pin, square wave on the other
      squareWave = 1'b1;
      wr(8'h0b, 64'h808080, 3);
      wr(8'h0e, 8'h02, 1);
      wr(8'h0f, 64'h0, 1);
      tick(40'h0045120317, 8'h02, 2'b01);
      wr(8'h0f, 8'h01, 1);
      rd(8'h0f, 8'h00);
      repeat (3) @(negedge sys_clk);
      chk(8'h03, {6'h0, pIrqN, sIrqN});
      results();
   end
endmodule
